/* lpa_pkg.sv */
// package of constants and carriers for the linefeed power alarm block
package lpa_pkg;
    // ==========================================================
    // register offsets (word index on the plain register port)
    localparam logic [3:0] REG_TOTAL_POWER_SUM  = 4'h0;
    localparam logic [3:0] REG_POWER_LIMIT_A    = 4'h1;
    localparam logic [3:0] REG_POWER_LIMIT_B    = 4'h2;
    localparam logic [3:0] REG_POWER_LIMIT_C    = 4'h3;
    localparam logic [3:0] REG_THERMAL_POLE_A   = 4'h4;
    localparam logic [3:0] REG_THERMAL_POLE_B   = 4'h5;
    localparam logic [3:0] REG_THERMAL_POLE_C   = 4'h6;
    localparam logic [3:0] REG_ALARM_PENDING    = 4'h7;
    localparam logic [3:0] REG_ALARM_ENABLE     = 4'h8;
    localparam logic [3:0] REG_LINEFEED_STATE   = 4'h9;
    // ==========================================================
    // field positions and reset values
    localparam int          POLE_LSB            = 3;
    localparam int          POLE_FRAC_BITS      = 12;
    localparam logic [15:0] RST_LIMIT           = 16'hffff;
    localparam logic [15:0] RST_POLE            = 16'h0000;
    localparam logic [5:0]  RST_ENABLE          = 6'h00;
    localparam logic [2:0]  LF_OPEN             = 3'h0;
    localparam logic [2:0]  RST_LINEFEED        = 3'h0;
    // offset of 0.75 V in voltage sample units (4.907 mV per lsb)
    localparam logic [15:0] VCE_OFFSET          = 16'h0099;
    // ==========================================================
    // timing: power calculation rate and derived cycle count
    localparam int          CLK_HZ              = 20000000;
    localparam int          CALC_HZ             = 800;
    localparam int          CALC_CYCLES         = CLK_HZ / CALC_HZ;

    // one sample set from the sense converter
    typedef struct packed {
        logic [15:0] tip;
        logic [15:0] ring;
        logic [15:0] bat;
        logic [15:0] res_drop_a;
        logic [15:0] res_drop_b;
        logic [5:0][15:0] cur;
    } lpa_sample_s;

    // plain register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } lpa_regreq_s;
endpackage : lpa_pkg

/* lpa_power_alarm.sv */
// linefeed power estimator, thermal filter and alarm with open forcing
//
// What this block does
// - Each sample period the power of transistors one and two is tip or ring magnitude plus 0.75 V times their current.
// - In discrete mode transistors three and four use battery minus resistor drop, five and six battery minus ring or tip minus drop, times current.
// - In integrated mode all six terms are summed, three and four using battery plus 0.75 V, five and six battery minus ring or tip.
// - Every power value is low-pass filtered at the 800 Hz calculation rate before comparison.
// - Each pole is a 12-bit plus sign value in bits 15 to 3, one pole per transistor pair.
// - Filtered power is compared to one 16-bit threshold per transistor pair.
// - A pending bit is set on the rising edge of the comparison and held until software clears it.
// - Each of six pending bits has its own enable gating the interrupt.
// - In integrated mode only the total is compared, using the first pair pole and threshold.
// - In integrated mode the total alarm shows on the first pending bit gated by the first enable only.
// - In integrated mode the first threshold and total sum use the coarser 1059.6 uW lsb.
// - Any alarm, masked or not, forces the line open until software writes a new state.
// - The total power is readable as a 16-bit read-only value.
// - New voltage and current samples arrive at 800 Hz.
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module lpa_power_alarm (
    // clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  rst_n_i,
    // sense converter samples
    input  wire lpa_pkg::lpa_sample_s  sample_i,
    input  wire logic                  sample_valid_i,
    // integrated linefeed sense link
    input  wire logic                  thermal_sense_link_i,
    // register port
    input  wire lpa_pkg::lpa_regreq_s  reg_i,
    output logic [15:0]                rdata_o,
    // line state and interrupt
    output logic [2:0]                 linefeed_state_o,
    output logic                       irq_o
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [2:0][15:0] limit;
        logic [2:0][15:0] pole;
        logic [5:0][15:0] filt;
        logic [5:0]       cmp_q;
        logic [5:0]       pend;
        logic [5:0]       en;
        logic [2:0]       lf;
        logic [15:0]      total_power_sum;
        logic [15:0]      rdata;
    } lpa_state_s;

    lpa_state_s r;
    lpa_state_s next_r;

    logic [5:0][15:0] pw;
    logic [5:0][15:0] filt_new;
    logic [5:0]       cmp;
    logic [5:0]       hit;
    logic             integ;
    logic [15:0]      vt;
    logic [15:0]      vr;
    logic [15:0]      vb;

    assign integ = thermal_sense_link_i;
    // magnitudes of the signed voltage samples
    assign vt = sample_i.tip[15] ? 16'(-sample_i.tip) : sample_i.tip;
    assign vr = sample_i.ring[15] ? 16'(-sample_i.ring) : sample_i.ring;
    assign vb = sample_i.bat[15] ? 16'(-sample_i.bat) : sample_i.bat;

    // scaled product: voltage times current, keep upper half
    function automatic logic [15:0] mulp(input logic [15:0] v,
                                         input logic [15:0] i);
        logic [31:0] p;
        p = v * i;
        return p[31:16];
    endfunction

    // saturating difference, negative collector voltage counts as zero
    function automatic logic [15:0] sub0(input logic [15:0] a,
                                         input logic [15:0] b);
        return (a > b) ? 16'(a - b) : 16'h0000;
    endfunction

    // per-transistor power estimates
    always_comb begin
        pw[0] = mulp(16'(vt + lpa_pkg::VCE_OFFSET), sample_i.cur[0]);
        pw[1] = mulp(16'(vr + lpa_pkg::VCE_OFFSET), sample_i.cur[1]);
        if (integ) begin
            pw[2] = mulp(16'(vb + lpa_pkg::VCE_OFFSET),
                         sample_i.cur[2]);
            pw[3] = mulp(16'(vb + lpa_pkg::VCE_OFFSET),
                         sample_i.cur[3]);
            pw[4] = mulp(sub0(vb, vr), sample_i.cur[4]);
            pw[5] = mulp(sub0(vb, vt), sample_i.cur[5]);
        end else begin
            pw[2] = mulp(sub0(vb, sample_i.res_drop_a),
                         sample_i.cur[2]);
            pw[3] = mulp(sub0(vb, sample_i.res_drop_b),
                         sample_i.cur[3]);
            pw[4] = mulp(sub0(sub0(vb, vr), sample_i.res_drop_a),
                         sample_i.cur[4]);
            pw[5] = mulp(sub0(sub0(vb, vt), sample_i.res_drop_b),
                         sample_i.cur[5]);
        end
    end

    // total power: the sum saturates so an overload never wraps to low
    logic [18:0] sum_w;
    logic [15:0] total_power_sum_w;
    always_comb begin
        sum_w = 19'(pw[0]) + 19'(pw[1]) + 19'(pw[2]) + 19'(pw[3])
              + 19'(pw[4]) + 19'(pw[5]);
        total_power_sum_w = (sum_w[18:16] != 3'h0) ? 16'hffff : sum_w[15:0];
    end

    // filter and compare per transistor; integrated mode uses slot 0 only
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_ch
            logic [15:0] src;
            logic [15:0] lim;
            logic [12:0] coef;
            logic signed [17:0] diff;
            logic signed [31:0] step;
            assign src  = (g == 0 && integ) ? total_power_sum_w : pw[g];
            assign lim  = r.limit[g / 2];
            assign coef = r.pole[g / 2][15:lpa_pkg::POLE_LSB];
            assign diff = 18'(signed'({2'b00, src}))
                        - 18'(signed'({2'b00, r.filt[g]}));
            assign step = (32'(diff) * 32'(signed'(coef)))
                        >>> lpa_pkg::POLE_FRAC_BITS;
            // wrap is harmless: the step never overshoots the target
            assign filt_new[g] = 16'(32'(r.filt[g]) + step);
            assign cmp[g] = (integ && g != 0) ? 1'b0
                          : (r.filt[g] > lim);
            assign hit[g] = cmp[g] & ~r.cmp_q[g];
        end
    endgenerate

    // next-state logic
    always_comb begin
        next_r = r;
        next_r.rdata = 16'h0000;
        // a new sample set drives one filter step and one comparison
        if (sample_valid_i) begin
            next_r.filt = filt_new;
            next_r.cmp_q = cmp;
            next_r.total_power_sum = total_power_sum_w;
        end
        // software writes
        if (reg_i.wr) begin
            unique case (reg_i.addr)
                lpa_pkg::REG_POWER_LIMIT_A:  next_r.limit[0] = reg_i.wdata;
                lpa_pkg::REG_POWER_LIMIT_B:  next_r.limit[1] = reg_i.wdata;
                lpa_pkg::REG_POWER_LIMIT_C:  next_r.limit[2] = reg_i.wdata;
                lpa_pkg::REG_THERMAL_POLE_A: next_r.pole[0] = reg_i.wdata;
                lpa_pkg::REG_THERMAL_POLE_B: next_r.pole[1] = reg_i.wdata;
                lpa_pkg::REG_THERMAL_POLE_C: next_r.pole[2] = reg_i.wdata;
                lpa_pkg::REG_ALARM_PENDING:
                    next_r.pend = r.pend & ~reg_i.wdata[5:0];
                lpa_pkg::REG_ALARM_ENABLE:   next_r.en = reg_i.wdata[5:0];
                lpa_pkg::REG_LINEFEED_STATE:
                    next_r.lf = reg_i.wdata[2:0];
                default: ;
            endcase
        end
        // new alarms win over a clear and over a state write
        if (sample_valid_i && (hit != 6'h00)) begin
            next_r.pend = next_r.pend | hit;
            next_r.lf = lpa_pkg::LF_OPEN;
        end
        // read data, one cycle after the strobe
        if (reg_i.rd) begin
            unique case (reg_i.addr)
                lpa_pkg::REG_TOTAL_POWER_SUM: next_r.rdata = r.total_power_sum;
                lpa_pkg::REG_POWER_LIMIT_A:   next_r.rdata = r.limit[0];
                lpa_pkg::REG_POWER_LIMIT_B:   next_r.rdata = r.limit[1];
                lpa_pkg::REG_POWER_LIMIT_C:   next_r.rdata = r.limit[2];
                lpa_pkg::REG_THERMAL_POLE_A:  next_r.rdata = r.pole[0];
                lpa_pkg::REG_THERMAL_POLE_B:  next_r.rdata = r.pole[1];
                lpa_pkg::REG_THERMAL_POLE_C:  next_r.rdata = r.pole[2];
                lpa_pkg::REG_ALARM_PENDING:
                    next_r.rdata = {10'h000, r.pend};
                lpa_pkg::REG_ALARM_ENABLE:
                    next_r.rdata = {10'h000, r.en};
                lpa_pkg::REG_LINEFEED_STATE:
                    next_r.rdata = {13'h0000, r.lf};
                default: next_r.rdata = 16'h0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            r       <= '0;
            r.limit <= {3{lpa_pkg::RST_LIMIT}};
            r.pole  <= {3{lpa_pkg::RST_POLE}};
            r.en    <= lpa_pkg::RST_ENABLE;
            r.lf    <= lpa_pkg::RST_LINEFEED;
        end else begin
            r <= next_r;
        end
    end

    // outputs; integrated mode uses only the first enable
    assign rdata_o = r.rdata;
    assign linefeed_state_o = r.lf;
    assign irq_o = integ ? (r.pend[0] & r.en[0])
                         : |(r.pend & r.en);
endmodule : lpa_power_alarm
`default_nettype wire

/* lpa_power_alarm_monitor.sv */
// port checker for the linefeed power alarm block
`timescale 1ns/1ns
`default_nettype none
module lpa_power_alarm_monitor (
    // clock, reset and inputs
    input wire logic                 mclk_i,
    input wire logic                 rst_n_i,
    input wire lpa_pkg::lpa_sample_s sample_i,
    input wire logic                 sample_valid_i,
    input wire logic                 thermal_sense_link_i,
    input wire lpa_pkg::lpa_regreq_s reg_i,
    // outputs under watch
    input wire logic [15:0]          rdata_o,
    input wire logic [2:0]           linefeed_state_o,
    input wire logic                 irq_o
);
    // ==========================================================
    // decoded writes; alarm set wins over the state write and the pending clear in one cycle
    logic       wr_lf;
    logic       wr_en;
    logic       wr_pd;
    logic [2:0] lf_req;
    assign wr_lf  = reg_i.wr && reg_i.addr == lpa_pkg::REG_LINEFEED_STATE;
    assign wr_en  = reg_i.wr && reg_i.addr == lpa_pkg::REG_ALARM_ENABLE;
    assign wr_pd  = reg_i.wr && reg_i.addr == lpa_pkg::REG_ALARM_PENDING;
    assign lf_req = reg_i.wdata[2:0];
    // ==========================================================
    // assertions
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_read_idle: assert property (!reg_i.rd |=> rdata_o == 16'h0000)
        else $error("read data outside its slot");
    a_read_unmapped: assert property (reg_i.rd && reg_i.addr > 4'h9 |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_open_alarm: assert property ($rose(irq_o) && !$past(wr_en) |-> linefeed_state_o == lpa_pkg::LF_OPEN)
        else $error("alarm without open line");
    a_alarm_sample: assert property ($rose(irq_o) && !$past(wr_en) |-> $past(sample_valid_i))
        else $error("alarm outside a sample");
    a_state_cause: assert property ($changed(linefeed_state_o) |-> $past(wr_lf) || $past(sample_valid_i))
        else $error("line state moved alone");
    a_state_write: assert property (wr_lf && !sample_valid_i |=> linefeed_state_o == $past(lf_req))
        else $error("line state write lost");
    a_irq_cause: assert property ($changed(irq_o) |-> $past(reg_i.wr) || $past(sample_valid_i))
        else $error("irq moved alone");
    a_mask_all: assert property (wr_en && reg_i.wdata[5:0] == 6'h00 |=> !irq_o)
        else $error("irq with all masked");
    a_clear_all: assert property (wr_pd && reg_i.wdata[5:0] == 6'h3f && !sample_valid_i |=> !irq_o)
        else $error("irq after full clear");
endmodule // lpa_power_alarm_monitor
`default_nettype wire

/* lpa_sense_model.sv */
// sense converter model delivering one sample set per trigger
`timescale 1ns/1ns
`default_nettype none
module lpa_sense_model (
    // clock, reset, trigger and sample set
    input  wire logic                 mclk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 fire_i,
    input  wire lpa_pkg::lpa_sample_s set_i,
    // samples towards the block
    output var  lpa_pkg::lpa_sample_s sample_o,
    output logic                      valid_o
);
    // one pulse per conversion; the trigger stands in for 800 Hz pacing
    always_ff @(posedge mclk_i) begin
        valid_o <= rst_n_i && fire_i;
        if (!rst_n_i) begin
            sample_o <= '0;
        end else if (fire_i) begin
            sample_o <= set_i;
        end
    end
endmodule // lpa_sense_model
`default_nettype wire

/* test_lpa_power_alarm.sv */
// self-checking bench for the linefeed power alarm block
`timescale 1ns/1ns
`default_nettype none
module test_lpa_power_alarm;
    // ==========================================================
    // signals; only q5 and q6 carry current in integrated mode
    logic                 mclk_i = 1'b0;
    logic                 rst_n_i = 1'b0;
    logic                 fire = 1'b0;
    logic                 link = 1'b0;
    lpa_pkg::lpa_sample_s set = '{16'h0800, 16'h1000, 16'h2000, 16'h0, 16'h0,
                                  {6{16'h1000}}};
    lpa_pkg::lpa_sample_s sample;
    logic                 valid;
    lpa_pkg::lpa_regreq_s req = '0;
    logic [15:0]          rdata;
    logic [2:0]           lf;
    logic                 irq;
    int                   miscompares = 0;
    int                   num_checks = 0;
    lpa_sense_model i_sense (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .fire_i(fire),
        .set_i(set), .sample_o(sample), .valid_o(valid));
    lpa_power_alarm i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sample_i(sample),
        .sample_valid_i(valid), .thermal_sense_link_i(link), .reg_i(req),
        .rdata_o(rdata), .linefeed_state_o(lf), .irq_o(irq));
    // 20 MHz clock
    initial begin
        forever #25 mclk_i = ~mclk_i;
    end
    // ==========================================================
    // shared tasks
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk_i);
        req <= '0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk_i);
        req <= '{a, 16'h0, 1'b0, 1'b1};
        @(posedge mclk_i);
        req <= '0;
        #1 chk($sformatf("register %0d", a), rdata, exp);
    endtask
    task automatic samples(input int n);
        repeat (n) begin
            @(posedge mclk_i);
            fire <= 1'b1;
            @(posedge mclk_i);
            fire <= 1'b0;
            repeat (3) @(posedge mclk_i);
        end
    endtask
    task automatic do_reset();
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'b1;
    endtask
    // ==========================================================
    // scenarios; index 10 is unmapped, index 0 refuses writes
    task automatic t_registers();
        logic [15:0] exp [11] = '{16'h0, lpa_pkg::RST_LIMIT, lpa_pkg::RST_LIMIT,
            lpa_pkg::RST_LIMIT, lpa_pkg::RST_POLE, lpa_pkg::RST_POLE,
            lpa_pkg::RST_POLE, 16'h0, 16'h0, 16'h0, 16'h0};
        wr(lpa_pkg::REG_TOTAL_POWER_SUM, 16'h1234);
        for (int i = 0; i < 11; i++) rdchk(4'(i), exp[i]);
        for (int i = 1; i < 7; i++) wr(4'(i), 16'ha500 + 16'(i << 3));
        for (int i = 1; i < 7; i++) rdchk(4'(i), 16'ha500 + 16'(i << 3));
    endtask
    // one pair at a time crosses its limit; filters start at zero
    task automatic t_discrete();
        for (int i = 4; i < 7; i++) wr(4'(i), 16'h4000);
        for (int p = 0; p < 3; p++) begin
            for (int i = 1; i < 4; i++) wr(4'(i), (i == p + 1) ? 16'h0 : 16'hffff);
            wr(lpa_pkg::REG_LINEFEED_STATE, 16'h0005);
            #1 chk("written state", {13'h0, lf}, 16'h0005);
            wr(lpa_pkg::REG_ALARM_ENABLE, 16'h0000);
            samples(1);
            if (p == 0) rdchk(lpa_pkg::REG_ALARM_PENDING, 16'h0000);
            samples(1);
            rdchk(lpa_pkg::REG_ALARM_PENDING, 16'(3 << (2 * p)));
            chk("line state", {13'h0, lf}, {13'h0, lpa_pkg::LF_OPEN});
            chk("masked irq", {15'h0, irq}, 16'h0000);
            wr(lpa_pkg::REG_ALARM_ENABLE, 16'(1 << (2 * p)));
            #1 chk("enabled irq", {15'h0, irq}, 16'h0001);
            wr(lpa_pkg::REG_ALARM_PENDING, 16'h003f);
            samples(1);
            rdchk(lpa_pkg::REG_ALARM_PENDING, 16'h0000);
            chk("held open", {13'h0, lf}, {13'h0, lpa_pkg::LF_OPEN});
        end
    endtask
    task automatic t_integrated();
        do_reset();
        link <= 1'b1;
        set.cur <= {16'h1000, 16'h1000, 64'h0};
        for (int i = 1; i < 4; i++) wr(4'(i), 16'h0000);
        wr(lpa_pkg::REG_THERMAL_POLE_A, 16'h4000);
        wr(lpa_pkg::REG_ALARM_ENABLE, 16'h0002);
        samples(2);
        rdchk(lpa_pkg::REG_ALARM_PENDING, 16'h0001);
        chk("masked irq", {15'h0, irq}, 16'h0000);
        rdchk(lpa_pkg::REG_TOTAL_POWER_SUM, 16'h0280);
        wr(lpa_pkg::REG_ALARM_ENABLE, 16'h0001);
        #1 chk("enabled irq", {15'h0, irq}, 16'h0001);
    endtask
    // ==========================================================
    // verdict and run control
    task automatic end_of_test();
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        t_registers();
        t_discrete();
        t_integrated();
        end_of_test();
    end
    // watchdog so a hang still reaches the verdict
    initial begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        end_of_test();
    end
endmodule // test_lpa_power_alarm
bind lpa_power_alarm lpa_power_alarm_monitor i_mon (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .sample_i(sample_i), .sample_valid_i(sample_valid_i),
    .thermal_sense_link_i(thermal_sense_link_i), .reg_i(reg_i),
    .rdata_o(rdata_o), .linefeed_state_o(linefeed_state_o), .irq_o(irq_o));
`default_nettype wire
